// File: shared/snv_map.svh
`ifndef SNV_MAP_SVH
`define SNV_MAP_SVH
// ****************************************
// Device map and command codes
// ****************************************
`define SNV_A_CMD      9'h060
`define SNV_A_CS       9'h061
`define SNV_A_CFG2     9'h0AB
`define SNV_A_UPD      9'h1FD
`define SNV_C_COPY     16'hE904
`define SNV_C_RECALL   16'hE001
`define SNV_C_HIST     8'hE2
`define SNV_C_FULLRST  16'h000F
`define SNV_C_FWRST    16'h8000
`define SNV_C_UNLOCK   16'h0000
`define SNV_C_LOCK     16'h00F9
`define SNV_H_CFG      8'h9B
`define SNV_H_LOG      8'h9C
`define SNV_H_SEC      8'h9D
`define SNV_H_LO       8'h2E
`define SNV_H_HI       8'h91
`define SNV_FW_BIT     15
`define SNV_ERR_BIT    2
`define SNV_UPD_TOTAL  4'h8
// ****************************************
// Timing
// ****************************************
`define SNV_CLK_NS        20
`define SNV_T_RESET_NS    10000000
`define SNV_T_BLOCK_NS    8000000
`define SNV_T_RECALL_NS   1000000
`define SNV_T_RESET_CYC   ((`SNV_T_RESET_NS + `SNV_CLK_NS - 1) / `SNV_CLK_NS)
`define SNV_T_BLOCK_CYC   ((`SNV_T_BLOCK_NS + `SNV_CLK_NS - 1) / `SNV_CLK_NS)
`define SNV_T_RECALL_CYC  ((`SNV_T_RECALL_NS + `SNV_CLK_NS - 1) / `SNV_CLK_NS)
// ****************************************
// Controller registers
// ****************************************
`define SNV_R_CTRL    3'h0
`define SNV_R_ADDR    3'h1
`define SNV_R_WDATA   3'h2
`define SNV_R_STATUS  3'h3
`define SNV_R_RDATA   3'h4
`endif

// File: shared/snv_pkg.sv
package snv_pkg;
    typedef enum logic [3:0] {
        OP_NONE = 4'h0, OP_UNLOCK = 4'h1, OP_LOCK = 4'h2, OP_WRITE = 4'h3,
        OP_READ = 4'h4, OP_COMMIT = 4'h5, OP_RECALL = 4'h6, OP_HIST = 4'h7,
        OP_QUERY = 4'h8
    } snv_op_t;
    typedef enum logic [3:0] {
        K_END = 4'h0, K_WR = 4'h1, K_RD = 4'h2, K_ERR = 4'h3, K_POLL = 4'h4,
        K_UPD = 4'h5, K_WBLK = 4'h6, K_WREC = 4'h7, K_WRST = 4'h8
    } snv_kind_t;
    typedef struct packed {
        snv_kind_t   kind;
        logic [8:0]  addr;
        logic [15:0] data;
    } snv_step_t;
    typedef struct packed {
        logic        req;
        logic        we;
        logic [8:0]  addr;
        logic [15:0] wdata;
    } snv_dev_req_t;
    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
    } snv_dev_rsp_t;
endpackage

// File: hw/snv_dev_port.sv
`timescale 1ns/1ps
`include "snv_map.svh"
module snv_dev_port import snv_pkg::*; (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset,
    // Word access request
    input  wire logic         start,
    input  wire logic         we,
    input  wire logic [8:0]   addr,
    input  wire logic [15:0]  wdata,
    output logic              done,
    output logic [15:0]       rdata,
    // Device register port
    output snv_dev_req_t      dev_req,
    input  wire snv_dev_rsp_t dev_rsp
);
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dev_req <= '0;
        end else if (start) begin
            dev_req <= '{req: 1'b1, we: we, addr: addr, wdata: wdata};
        end else if (dev_rsp.ack) begin
            dev_req.req <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done  <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            done <= dev_req.req & dev_rsp.ack;
            if (dev_req.req & dev_rsp.ack & ~dev_req.we) begin
                rdata <= dev_rsp.rdata;
            end
        end
    end
    property p_req_hold;
        @(posedge ref_clk) disable iff (reset)
        dev_req.req && !dev_rsp.ack |=> dev_req.req && $stable(dev_req.addr)
            && $stable(dev_req.wdata);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("Request dropped early.");
    property p_done_once;
        @(posedge ref_clk) disable iff (reset)
        done |-> !$past(done) && !dev_req.req;
    endproperty
    a_done_once: assert property (p_done_once) else $error("Done not a pulse.");
endmodule

// File: hw/snv_update_decode.sv
`timescale 1ns/1ps
`include "snv_map.svh"
module snv_update_decode (
    // Indicator word
    input  wire logic [15:0] word,
    // Decoded counts
    output logic [3:0]       used,
    output logic [3:0]       remaining
);
    logic [7:0] merged;
    logic [3:0] sum [0:8];
    // Both bytes carry the same thermometer; OR them so one bit dropped from either byte is tolerated.
    assign merged = word[15:8] | word[7:0];
    assign sum[0] = 4'h0;
    for (genvar i = 0; i < 8; i++) begin : g_cnt
        assign sum[i+1] = sum[i] + {3'h0, merged[i]};
    end
    assign used      = sum[8];
    assign remaining = `SNV_UPD_TOTAL - sum[8];
endmodule

// File: hw/snv_host_ctrl.sv
`timescale 1ns/1ps
`include "snv_map.svh"
module snv_host_ctrl import snv_pkg::*; #(
    parameter int RESET_CYC  = `SNV_T_RESET_CYC,
    parameter int BLOCK_CYC  = `SNV_T_BLOCK_CYC,
    parameter int RECALL_CYC = `SNV_T_RECALL_CYC
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset,
    // Wishbone slave
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic [31:0]       wb_dat_o,
    output logic              wb_ack_o,
    // Device register port
    output snv_dev_req_t      dev_req,
    input  wire snv_dev_rsp_t dev_rsp
);
    // ****************************************
    // State
    // ****************************************
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_FETCH = 3'b001,
        S_ACC   = 3'b010,
        S_WAIT  = 3'b011,
        S_DONE  = 3'b100
    } snv_state_t;

    snv_state_t  st_ff;
    snv_op_t     op_ff;
    logic [3:0]  pc_ff;
    logic [7:0]  sub_ff;
    logic [8:0]  addr_ff;
    logic [15:0] wdata_ff;
    logic [15:0] rd_ff;
    logic [23:0] wcnt_ff;
    logic        done_ff;
    logic        err_ff;
    logic        refused_ff;
    logic        upd_ok_ff;
    logic [3:0]  used_ff;
    logic [3:0]  rem_ff;
    snv_step_t   cur;
    logic        acc_start;
    logic        acc_done;
    logic [15:0] acc_rdata;
    logic [3:0]  dec_used;
    logic [3:0]  dec_rem;
    logic        bus_req;
    logic        bus_wr;
    logic        ctrl_wr;
    logic        op_ok;
    logic        exhausted;
    logic        go;
    logic        poll_again;
    logic        copy_bad;

    // ****************************************
    // Sequence table
    // ****************************************
    function automatic snv_step_t mk(input snv_kind_t k, input logic [8:0] a,
                                     input logic [15:0] d);
        snv_step_t s;
        s.kind = k;
        s.addr = a;
        s.data = d;
        return s;
    endfunction

    function automatic snv_step_t seq_step(input snv_op_t op, input logic [3:0] pc,
                                           input logic [7:0] sub, input logic [8:0] a,
                                           input logic [15:0] d);
        snv_step_t s;
        s = mk(K_END, 9'h000, 16'h0000);
        case (op)
            OP_UNLOCK, OP_HIST, OP_QUERY: begin
                case (pc)
                    4'h0, 4'h1: s = mk(K_WR, `SNV_A_CS, `SNV_C_UNLOCK);
                    4'h2: s = mk(K_WR, `SNV_A_CMD, (op == OP_QUERY) ?
                                 {`SNV_C_HIST, `SNV_H_CFG} : {`SNV_C_HIST, sub});
                    4'h3: s = mk(K_WREC, 9'h000, 16'h0000);
                    4'h4: s = mk(K_UPD, `SNV_A_UPD, 16'h0000);
                    4'h5, 4'h6: s = mk(K_WR, `SNV_A_CS, `SNV_C_LOCK);
                    default: s = mk(K_END, 9'h000, 16'h0000);
                endcase
                if (op == OP_UNLOCK && pc > 4'h1) begin
                    s = mk(K_END, 9'h000, 16'h0000);
                end
                if (op == OP_HIST && pc > 4'h3) begin
                    s = mk(K_END, 9'h000, 16'h0000);
                end
            end
            OP_LOCK: begin
                if (pc < 4'h2) begin
                    s = mk(K_WR, `SNV_A_CS, `SNV_C_LOCK);
                end
            end
            OP_WRITE: begin
                if (pc == 4'h0) begin
                    s = mk(K_WR, a, d);
                end
            end
            OP_READ: begin
                if (pc == 4'h0) begin
                    s = mk(K_RD, a, 16'h0000);
                end
            end
            OP_RECALL: begin
                case (pc)
                    4'h0: s = mk(K_WR, `SNV_A_CMD, `SNV_C_RECALL);
                    4'h1: s = mk(K_WREC, 9'h000, 16'h0000);
                    default: s = mk(K_END, 9'h000, 16'h0000);
                endcase
            end
            OP_COMMIT: begin
                // Shadow words are written beforehand with single writes, then one copy.
                case (pc)
                    4'h0: s = mk(K_WR, `SNV_A_CS, `SNV_C_UNLOCK);
                    4'h1: s = mk(K_WR, `SNV_A_CMD, `SNV_C_COPY);
                    4'h2: s = mk(K_WBLK, 9'h000, 16'h0000);
                    4'h3: s = mk(K_ERR, `SNV_A_CS, 16'h0000);
                    4'h4: s = mk(K_WR, `SNV_A_CMD, `SNV_C_FULLRST);
                    4'h5: s = mk(K_WRST, 9'h000, 16'h0000);
                    4'h6, 4'h7: s = mk(K_WR, `SNV_A_CS, `SNV_C_UNLOCK);
                    4'h8: s = mk(K_WR, `SNV_A_CFG2, `SNV_C_FWRST);
                    4'h9: s = mk(K_POLL, `SNV_A_CFG2, 16'h0000);
                    4'hA, 4'hB: s = mk(K_WR, `SNV_A_CS, `SNV_C_LOCK);
                    default: s = mk(K_END, 9'h000, 16'h0000);
                endcase
            end
            default: s = mk(K_END, 9'h000, 16'h0000);
        endcase
        return s;
    endfunction

    assign cur = seq_step(op_ff, pc_ff, sub_ff, addr_ff, wdata_ff);

    // ****************************************
    // Order decode
    // ****************************************
    assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr    = bus_req & wb_we_i & (wb_sel_i[1:0] == 2'b11);
    assign ctrl_wr   = bus_wr & (wb_adr_i[4:2] == `SNV_R_CTRL);
    // A query already showed every update spent; another copy would only wear the array.
    assign exhausted = upd_ok_ff & (rem_ff == 4'h0);
    always_comb begin
        op_ok = 1'b1;
        case (snv_op_t'(wb_dat_i[3:0]))
            OP_UNLOCK, OP_LOCK, OP_WRITE, OP_READ, OP_RECALL, OP_QUERY: op_ok = 1'b1;
            OP_COMMIT: op_ok = ~exhausted;
            OP_HIST: op_ok = (wb_dat_i[15:8] >= `SNV_H_CFG && wb_dat_i[15:8] <= `SNV_H_SEC)
                             || (wb_dat_i[15:8] >= `SNV_H_LO
                                 && wb_dat_i[15:8] <= `SNV_H_HI);
            default: op_ok = 1'b0;
        endcase
    end
    // Orders arriving while a sequence runs are dropped, never queued.
    assign go = ctrl_wr & (st_ff == S_IDLE) & op_ok;
    assign acc_start  = (st_ff == S_FETCH) & (cur.kind inside {K_WR, K_RD, K_ERR,
                                                               K_POLL, K_UPD});
    assign poll_again = (cur.kind == K_POLL) & acc_rdata[`SNV_FW_BIT];
    assign copy_bad   = (cur.kind == K_ERR) & acc_rdata[`SNV_ERR_BIT];

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_ff <= S_IDLE;
            pc_ff <= 4'h0;
        end else begin
            case (st_ff)
                S_IDLE: begin
                    if (go) begin
                        st_ff <= S_FETCH;
                        pc_ff <= 4'h0;
                    end
                end
                S_FETCH: begin
                    case (cur.kind)
                        K_WR, K_RD, K_ERR, K_POLL, K_UPD: st_ff <= S_ACC;
                        K_WBLK, K_WREC, K_WRST: st_ff <= S_WAIT;
                        default: st_ff <= S_DONE;
                    endcase
                end
                S_ACC: begin
                    if (acc_done) begin
                        if (copy_bad) begin
                            st_ff <= S_DONE;
                        end else begin
                            st_ff <= S_FETCH;
                            if (!poll_again) begin
                                pc_ff <= pc_ff + 4'h1;
                            end
                        end
                    end
                end
                S_WAIT: begin
                    if (wcnt_ff == 24'h000000) begin
                        st_ff <= S_FETCH;
                        pc_ff <= pc_ff + 4'h1;
                    end
                end
                S_DONE: st_ff <= S_IDLE;
                default: st_ff <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wcnt_ff <= 24'h000000;
        end else if (st_ff == S_FETCH) begin
            case (cur.kind)
                K_WBLK: wcnt_ff <= 24'(BLOCK_CYC - 1);
                K_WREC: wcnt_ff <= 24'(RECALL_CYC - 1);
                K_WRST: wcnt_ff <= 24'(RESET_CYC - 1);
                default: wcnt_ff <= 24'h000000;
            endcase
        end else if (wcnt_ff != 24'h000000) begin
            wcnt_ff <= wcnt_ff - 24'h000001;
        end
    end

    // ****************************************
    // Orders and results
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            op_ff    <= OP_NONE;
            sub_ff   <= 8'h00;
            addr_ff  <= 9'h000;
            wdata_ff <= 16'h0000;
        end else begin
            if (go) begin
                op_ff  <= snv_op_t'(wb_dat_i[3:0]);
                sub_ff <= wb_dat_i[15:8];
            end
            if (bus_wr && wb_adr_i[4:2] == `SNV_R_ADDR && st_ff == S_IDLE) begin
                addr_ff <= wb_dat_i[8:0];
            end
            if (bus_wr && wb_adr_i[4:2] == `SNV_R_WDATA && st_ff == S_IDLE) begin
                wdata_ff <= wb_dat_i[15:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done_ff    <= 1'b0;
            err_ff     <= 1'b0;
            refused_ff <= 1'b0;
            rd_ff      <= 16'h0000;
        end else begin
            if (go) begin
                done_ff    <= 1'b0;
                refused_ff <= 1'b0;
            end else if (ctrl_wr && st_ff == S_IDLE) begin
                refused_ff <= 1'b1;
            end else if (st_ff == S_DONE) begin
                done_ff <= 1'b1;
            end
            if (go && wb_dat_i[3:0] == OP_COMMIT) begin
                err_ff <= 1'b0;
            end else if (st_ff == S_ACC && acc_done && cur.kind == K_ERR) begin
                err_ff <= acc_rdata[`SNV_ERR_BIT];
            end
            if (st_ff == S_ACC && acc_done && cur.kind == K_RD) begin
                rd_ff <= acc_rdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            upd_ok_ff <= 1'b0;
            used_ff   <= 4'h0;
            rem_ff    <= 4'h0;
        end else if (st_ff == S_ACC && acc_done && cur.kind == K_UPD) begin
            upd_ok_ff <= 1'b1;
            used_ff   <= dec_used;
            rem_ff    <= dec_rem;
        end else if (st_ff == S_ACC && acc_done && cur.kind == K_ERR) begin
            upd_ok_ff <= 1'b0;
        end
    end

    // ****************************************
    // Wishbone answer
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h00000000;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i[4:2])
                    `SNV_R_ADDR:   wb_dat_o <= {23'h000000, addr_ff};
                    `SNV_R_WDATA:  wb_dat_o <= {16'h0000, wdata_ff};
                    `SNV_R_STATUS: wb_dat_o <= {16'h0000, rem_ff, used_ff, 3'h0,
                                                refused_ff, upd_ok_ff, err_ff,
                                                done_ff, st_ff != S_IDLE};
                    `SNV_R_RDATA:  wb_dat_o <= {16'h0000, rd_ff};
                    default:       wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // Submodules
    // ****************************************
    snv_dev_port u_port (
        .ref_clk (ref_clk),
        .reset   (reset),
        .start   (acc_start),
        .we      (cur.kind == K_WR),
        .addr    (cur.addr),
        .wdata   (cur.data),
        .done    (acc_done),
        .rdata   (acc_rdata),
        .dev_req (dev_req),
        .dev_rsp (dev_rsp)
    );

    snv_update_decode u_dec (
        .word      (acc_rdata),
        .used      (dec_used),
        .remaining (dec_rem)
    );

    // ****************************************
    // Checks
    // ****************************************
    sequence s_copy_issued;
        dev_req.req && dev_rsp.ack && dev_req.we && dev_req.addr == `SNV_A_CMD
            && dev_req.wdata == `SNV_C_COPY;
    endsequence
    sequence s_enter_wait;
        ##2 st_ff == S_FETCH ##1 st_ff == S_WAIT;
    endsequence
    property p_copy_waits;
        @(posedge ref_clk) disable iff (reset)
        s_copy_issued |-> s_enter_wait ##0 wcnt_ff == 24'(BLOCK_CYC - 1);
    endproperty
    a_copy_waits: assert property (p_copy_waits) else $error("Copy wait missing.");
    property p_wait_holds;
        @(posedge ref_clk) disable iff (reset)
        st_ff == S_WAIT && wcnt_ff != 24'h000000 |=> st_ff == S_WAIT && !dev_req.req;
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("Wait cut short.");
    property p_busy_ignore;
        @(posedge ref_clk) disable iff (reset)
        st_ff != S_IDLE && ctrl_wr |=> $stable(op_ff);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("Order taken while busy.");
    property p_err_latch;
        @(posedge ref_clk) disable iff (reset)
        st_ff == S_ACC && acc_done && copy_bad |=> err_ff ##1 done_ff;
    endproperty
    a_err_latch: assert property (p_err_latch) else $error("Copy error not latched.");
    property p_poll_repeat;
        @(posedge ref_clk) disable iff (reset)
        st_ff == S_ACC && acc_done && poll_again |=> st_ff == S_FETCH && $stable(pc_ff);
    endproperty
    a_poll_repeat: assert property (p_poll_repeat) else $error("Poll advanced early.");
    property p_refuse_spent;
        @(posedge ref_clk) disable iff (reset)
        ctrl_wr && st_ff == S_IDLE && wb_dat_i[3:0] == OP_COMMIT && exhausted
            |=> refused_ff && st_ff == S_IDLE;
    endproperty
    a_refuse_spent: assert property (p_refuse_spent) else $error("Spent copy started.");
    property p_count_sum;
        @(posedge ref_clk) disable iff (reset)
        upd_ok_ff |-> used_ff + rem_ff == `SNV_UPD_TOTAL;
    endproperty
    a_count_sum: assert property (p_count_sum) else $error("Update counts disagree.");
    property p_lock_pair;
        @(posedge ref_clk) disable iff (reset)
        st_ff == S_FETCH && op_ff == OP_LOCK && pc_ff == 4'h0
            |=> dev_req.req && dev_req.addr == `SNV_A_CS && dev_req.wdata == `SNV_C_LOCK;
    endproperty
    a_lock_pair: assert property (p_lock_pair) else $error("Lock write wrong.");
endmodule

// File: test/snv_dev_model.sv
`timescale 1ns/1ps
module snv_dev_model import snv_pkg::*; (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset,
    // Register port
    input  wire snv_dev_req_t dev_req,
    output snv_dev_rsp_t      dev_rsp
);
    // ****************************************
    // Device registers and shadow RAM
    // ****************************************
    logic [15:0] mem_ff [0:511];
    logic [3:0]  used_ff;
    logic [1:0]  wait_ff;
    logic [8:0]  a;
    logic [15:0] d;
    assign a = dev_req.addr;
    assign d = dev_req.wdata;
    // The answer delay follows the low address bits, so some accesses stall.
    always_ff @(posedge ref_clk) begin
        dev_rsp.ack <= 1'b0;
        dev_rsp.rdata <= ~dev_rsp.rdata;
        if (reset) begin
            used_ff <= 4'h1;
            wait_ff <= 2'h0;
            dev_rsp.rdata <= 16'h0000;
            mem_ff[9'h061] <= 16'h0000;
        end else if (dev_req.req && !dev_rsp.ack) begin
            wait_ff <= wait_ff + 2'h1;
            if (wait_ff == a[1:0]) begin
                wait_ff <= 2'h0;
                dev_rsp.ack <= 1'b1;
                dev_rsp.rdata <= mem_ff[a];
                if (!dev_req.we && a == 9'h0AB) mem_ff[9'h0AB][15] <= 1'b0;
                if (dev_req.we) mem_ff[a] <= d;
                if (dev_req.we && a == 9'h060 && d == 16'hE904) begin
                    if (used_ff == 4'h8) mem_ff[9'h061][2] <= 1'b1;
                    else used_ff <= used_ff + 4'h1;
                end
                if (dev_req.we && a == 9'h060 && d == 16'hE29B)
                    mem_ff[9'h1FD] <= 16'h00FF >> (4'h8 - used_ff);
                if (dev_req.we && a == 9'h061) mem_ff[9'h061] <= 16'h0000;
            end
        end
    end
endmodule

// File: test/snv_host_ctrl_tb.sv
`timescale 1ns/1ps
module snv_host_ctrl_tb import snv_pkg::*; ;
    // ****************************************
    // Bench
    // ****************************************
    logic         ref_clk, reset, por, cyc, we;
    logic [7:0]   adr;
    logic [31:0]  dat, wb_dat_o, st;
    logic         wb_ack_o;
    logic [7:0]   subs [5] = '{8'h9B, 8'h9C, 8'h9D, 8'h2E, 8'h91};
    snv_dev_req_t dev_req;
    snv_dev_rsp_t dev_rsp;
    int           errors = 0, samples_checked = 0, cycles = 0;
    snv_host_ctrl #(.RESET_CYC(20), .BLOCK_CYC(20), .RECALL_CYC(20)) snv_host_ctrl_inst (
        .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .dev_req(dev_req), .dev_rsp(dev_rsp));
    // The device keeps its copy count over a controller reset, so it has its own power-on reset.
    snv_dev_model snv_dev_model_inst (.ref_clk(ref_clk), .reset(por),
        .dev_req(dev_req), .dev_rsp(dev_rsp));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // The request stands until the rising edge that samples ack high; data is taken there.
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
        @(posedge ref_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {16'h0000, d};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
    endtask
    task automatic run_op(input logic [15:0] ctl, output logic [31:0] q);
        int n = 0;
        wb(1'b1, 8'h00, ctl, q);
        do wb(1'b0, 8'h0C, 16'h0000, q); while (q[1] !== 1'b1 && q[4] !== 1'b1 && ++n < 5000);
        if (n >= 5000) errors++;
    endtask
    task automatic t_word();
        wb(1'b1, 8'h04, 16'h01C0, st);
        wb(1'b1, 8'h08, 16'hA5C3, st);
        run_op(16'h0001, st);
        run_op(16'h0003, st);
        run_op(16'h0004, st);
        wb(1'b0, 8'h10, 16'h0000, st);
        chk("rdata", st[15:0], 16'hA5C3);
        wb(1'b0, 8'h1C, 16'h0000, st);
        chk("unmapped", st[15:0], 16'h0000);
        $display("word test done");
    endtask
    task automatic t_ops();
        wb(1'b1, 8'h00, 16'h0006, st);
        run_op(16'h0008, st);
        chk("busy_drop", 16'({st[4], st[3]}), 16'h0000);
        chk("recall", 16'(st[1]), 16'h0001);
        foreach (subs[k]) begin
            run_op({subs[k], 8'h07}, st);
            chk("history", 16'(st[1]), 16'h0001);
        end
        run_op(16'h0002, st);
        chk("lock", 16'(st[1]), 16'h0001);
        run_op(16'h000F, st);
        chk("badop", 16'(st[4]), 16'h0001);
        $display("ops test done");
    endtask
    task automatic t_copies();
        for (int i = 1; i <= 8; i++) begin
            run_op(16'h0008, st);
            chk("used", 16'(st[11:8]), 16'(i));
            chk("left", 16'(st[15:12]), 16'(8 - i));
            run_op(16'h0005, st);
            chk("commit", 16'({st[4], st[2]}), (i < 8) ? 16'h0000 : 16'h0002);
        end
        $display("copy test done");
    endtask
    // A controller reset forgets the spent count, so the device itself must refuse the copy.
    task automatic t_reset_err();
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        wb(1'b0, 8'h0C, 16'h0000, st);
        chk("rst_status", st[15:0], 16'h0000);
        run_op(16'h0005, st);
        chk("spent", 16'({st[4], st[2], st[1]}), 16'h0003);
        $display("reset error test done");
    endtask
    initial begin
        reset = 1'b1;
        por = 1'b1;
        cyc = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        dat = 32'h00000000;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        por <= 1'b0;
        t_word();
        t_ops();
        t_copies();
        t_reset_err();
        give_verdict();
    end
endmodule
